// ===== bench/stw_slave_model.sv
// Serial slave model on the shared data wire.
// Assumes the bench resolves the wire level and feeds it back here.
`timescale 1ns/10ps
module stw_slave_model (
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic sd_oe_n,
    input wire logic wire_lvl,
    input wire logic [31:0] word,
    input wire logic [5:0] nbits,
    output logic drv,
    output logic [31:0] got,
    output int rises,
    output int driven
);
    logic [31:0] sh;
    initial begin
        drv = 1'b0;
        sh = '0;
    end
    always @(negedge sel_n) begin
        sh = word << (32 - nbits);
        drv = sh[31];
        got = '0;
        rises = 0;
        driven = 0;
    end
    always @(negedge sclk) begin
        if (!sel_n) begin
            sh = sh << 1;
            drv = sh[31];
        end
    end
    always @(posedge sclk) begin
        rises++;
        if (!sd_oe_n) begin
            driven++;
            got = {got[30:0], wire_lvl};
        end
    end
    // Deselected: never leave a stale level
    always @(posedge sel_n) drv = ~drv;
endmodule : stw_slave_model

// ===== bench/testbench.sv
// Self-checking bench of the three-wire serial controller.
// Assumes the slave model is compiled first; one clock, sync reset.
`timescale 1ns/10ps
module testbench;
    logic clk;
    logic sys_rst;
    stw_pkg::stw_bus_t bus;
    logic [31:0] rd_data;
    logic sclk, sel_n, sd_out, sd_oe_n, irq, slv_drv, sd_wire, rd_d;
    logic [31:0] s_word, got, v, w;
    logic [31:0] exp_q[$];
    logic [31:0] adr_q[$];
    logic [5:0] s_bits;
    int rises, driven, bad_count, compares;
    // Block drives while its enable is low
    assign sd_wire = sd_oe_n ? slv_drv : sd_out;
    stw_ctrl #(.DEPTH(4)) dut_u (.clk(clk), .sys_rst(sys_rst), .bus(bus), .rd_data(rd_data),
        .sclk(sclk), .sel_n(sel_n), .sd_out(sd_out), .sd_oe_n(sd_oe_n), .sd_in(sd_wire),
        .irq(irq));
    stw_slave_model slv_u (.sclk(sclk), .sel_n(sel_n), .sd_oe_n(sd_oe_n), .wire_lvl(sd_wire),
        .word(s_word), .nbits(s_bits), .drv(slv_drv), .got(got), .rises(rises),
        .driven(driven));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] a(input logic [7:0] ofs);
        return {stw_pkg::BASE_ADDR[31:8], ofs};
    endfunction : a
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        compares++;
        if (exp !== seen) begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            bad_count++;
        end
    endtask : chk
    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
        exp_q.push_back(exp);
        adr_q.push_back(addr);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 32'h0000_0000};
        @(posedge clk);
        bus.rd <= 1'b0;
    endtask : rd
    task automatic wait_sel(input logic lvl);
        int n;
        n = 0;
        while (sel_n !== lvl && n < 3000) begin
            @(posedge clk);
            n++;
        end
        chk("sel_n", {31'h0, lvl}, {31'h0, sel_n});
    endtask : wait_sel
    task automatic complete_run();
        $display("Checks %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run
    always @(posedge clk) rd_d <= bus.rd;
    // Read answers land one cycle late; judge them mid-cycle
    always @(negedge clk) begin
        if (rd_d === 1'b1) begin
            w = adr_q.pop_front();
            chk($sformatf("rd_data at %h", w), exp_q.pop_front(), rd_data);
        end
    end
    initial begin
        #200000;
        $display("Error watchdog expired");
        bad_count++;
        complete_run();
    end
    initial begin
        bus = '0;
        sys_rst = 1'b1;
        s_word = '0;
        s_bits = 6'h08;
        bad_count = 0;
        compares = 0;
        void'($urandom(25991));
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rd(a(8'h00), 32'h1C00_0000);
        rd(a(8'h0C), 32'h0000_0003);
        rd(a(8'h10), 32'h0000_0000);
        rd(a(8'h14), 32'h0000_0000);
        rd(a(8'h28), 32'h0000_0000);
        rd(a(8'h30), 32'h0000_0000);
        wr(a(8'h0C), 32'hFFFF_FFFF);
        rd(a(8'h0C), 32'h0000_0003);
        rd(a(8'h20), 32'h0000_0000);
        wr(a(8'h40), 32'hFFFF_FFFF);
        rd(a(8'h40), 32'h0000_0000);
        wr(32'h4050_0010, 32'h0000_00FF);
        rd(32'h4050_0010, 32'h0000_0000);
        rd(a(8'h10), 32'h0000_0000);
        v = $urandom;
        wr(a(8'h10), v);
        rd(a(8'h10), v);
        $display("Test registers done");
        wr(a(8'h10), 32'h0000_0008);
        wr(a(8'h04), 32'h0000_0007);
        wr(a(8'h30), 32'h0000_0001);
        v = $urandom;
        wr(a(8'h08), v);
        wr(a(8'h00), 32'h0000_0002);
        repeat (20) @(posedge clk);
        chk("sel_n four wire", 32'h1, {31'h0, sel_n});
        wr(a(8'h00), 32'h0040_0002);
        wait_sel(1'b0);
        wait_sel(1'b1);
        chk("sent bits", {24'h0, v[7:0]}, got);
        chk("send rises", 32'h0000_0008, rises);
        chk("driven rises", 32'h0000_0008, driven);
        rd(a(8'h0C), 32'h0000_0003);
        rd(a(8'h30), 32'h0000_0000);
        wr(a(8'h00), 32'h0040_0000);
        wr(a(8'h20), 32'h0000_0004);
        $display("Test send done");
        s_word = $urandom;
        s_bits = 6'h0C;
        wr(a(8'h28), 32'h0000_0001);
        wr(a(8'h00), 32'h0B40_0002);
        wait_sel(1'b0);
        wait_sel(1'b1);
        chk("receive rises", 32'h0000_000C, rises);
        chk("receive driven", 32'h0000_0000, driven);
        rd(a(8'h08), s_word & 32'h0000_0FFF);
        rd(a(8'h28), 32'h0000_0000);
        rd(a(8'h18), 32'h0000_0006);
        wr(a(8'h00), 32'h0B40_0000);
        wr(a(8'h20), 32'h0000_0005);
        rd(a(8'h18), 32'h0000_0002);
        wr(a(8'h28), 32'h0000_0005);
        wr(a(8'h00), 32'h0B40_0002);
        repeat (600) @(posedge clk);
        wr(a(8'h00), 32'h0B40_0000);
        rd(a(8'h18), 32'h0000_0007);
        rd(a(8'h0C), 32'h0000_000F);
        repeat (4) rd(a(8'h08), s_word & 32'h0000_0FFF);
        rd(a(8'h28), 32'h0000_0000);
        wr(a(8'h20), 32'h0000_0005);
        $display("Test receive done");
        wr(a(8'h14), 32'h0000_0002);
        rd(a(8'h1C), 32'h0000_0002);
        chk("irq masked in", 32'h1, {31'h0, irq});
        wr(a(8'h14), 32'h0000_0001);
        rd(a(8'h1C), 32'h0000_0000);
        chk("irq masked out", 32'h0, {31'h0, irq});
        rd(a(8'h14), 32'h0000_0001);
        repeat (3) @(posedge clk);
        $display("Test interrupt done");
        complete_run();
    end
endmodule : testbench

// ===== shared/stw_pkg.sv
// Constants and types of the three-wire serial controller.
// Assumes one system clock and a plain register port.
package stw_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [31:0] BASE_ADDR = 32'h4040_0000;
    localparam logic [7:0] OFS_CTRL0 = 8'h00;
    localparam logic [7:0] OFS_CTRL1 = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic [7:0] OFS_PRESC = 8'h10;
    localparam logic [7:0] OFS_IMASK = 8'h14;
    localparam logic [7:0] OFS_RAW = 8'h18;
    localparam logic [7:0] OFS_MASKED = 8'h1C;
    localparam logic [7:0] OFS_ICLR = 8'h20;
    localparam logic [7:0] OFS_DMA = 8'h24;
    localparam logic [7:0] OFS_RECEIVE_FRAME_COUNT = 8'h28;
    localparam logic [7:0] OFS_DUMMY = 8'h2C;
    localparam logic [7:0] OFS_TXFRM = 8'h30;
    localparam logic [7:0] OFS_ITEST = 8'h80;
    localparam logic [7:0] OFS_TDATA = 8'h8C;
    localparam logic [31:0] RST_CTRL0 = 32'h1C00_0000;
    localparam logic [31:0] RST_STAT = 32'h0000_0003;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    // ----------------------------------------
    // Fields
    // ----------------------------------------
    localparam int EN_BIT = 1;
    localparam int FMT_LSB = 21;
    localparam int DSS_LSB = 24;
    localparam int CSS_LSB = 0;
    localparam logic [1:0] FMT_FOUR_WIRE = 2'h0;
    localparam logic [1:0] FMT_THREE_WIRE = 2'h2;
    localparam int ST_TX_EMPTY = 0;
    localparam int ST_TX_NFULL = 1;
    localparam int ST_RX_NEMPTY = 2;
    localparam int ST_RX_FULL = 3;
    localparam int ST_BUSY = 4;
    localparam int IRQ_OVR = 0;
    localparam int IRQ_TXE = 1;
    localparam int IRQ_DONE = 2;
    localparam int IRQ_W = 3;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_RECV} stw_state_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [31:0] addr;
        logic [31:0] wdata;
    } stw_bus_t;
endpackage : stw_pkg

// ===== verilog/stw_ctrl.sv
// Three-wire half-duplex serial master with its register bank.
// Assumes a register master on clk and one shared data wire outside.
//
// Contract
// (RQ1) Frame format field resets to four-wire
// (RQ2) Format two runs three-wire master mode
// (RQ3) Shared data line multiplexed send versus receive
// (RQ4) Send bit count from command length
// (RQ5) Receive bit count from data size
// (RQ6) Software enables, waits before reading data
// (RQ7) Software clears enable after each transfer
// (RQ8) Software fills transmit FIFO before enabling
// (RQ9) Busy flag high while frame runs
// (RQ10) Bank decoded at fixed base address
// (RQ11) First control register resets nonzero value
// (RQ12) Status read-only, resets with low bits
// (RQ13) Prescale register read-write, resets zero
// (RQ14) Interrupt mask read-write, resets zero
// (RQ15) Raw status shows unmasked sources
// (RQ16) Masked status shows sources and mask
// (RQ17) Clear register write-only, clears latched bits
// (RQ18) Receive frame count read-write, frames left
// (RQ19) Transmit frame count read-write, frames left
// (RQ20) Receive frame count drops once per frame
// (RQ21) Mask one routes source to interrupt
// (RQ22) Unmapped offsets read zero, ignore writes
//
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
module stw_ctrl #(
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire stw_pkg::stw_bus_t bus,
    output logic [31:0] rd_data,
    output logic sclk,
    output logic sel_n,
    output logic sd_out,
    output logic sd_oe_n,
    input wire logic sd_in,
    output logic irq
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction : ptr_inc

    // ----------------------------------------
    // Register bank state
    // ----------------------------------------
    logic [31:0] ctrl0_reg, ctrl0_next, ctrl1_reg, ctrl1_next;
    logic [31:0] presc_reg, presc_next, imask_reg, imask_next;
    logic [31:0] dma_reg, dma_next, receive_frame_count_reg, receive_frame_count_next;
    logic [31:0] dummy_reg, dummy_next, txfrm_reg, txfrm_next;
    logic [31:0] itest_reg, itest_next, tdata_reg, tdata_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] sticky_reg, sticky_next;
    logic irq_reg, irq_next;
    // ----------------------------------------
    // FIFOs and engine state
    // ----------------------------------------
    logic [31:0] tx_mem [DEPTH];
    logic [31:0] rx_mem [DEPTH];
    logic [AW-1:0] tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
    logic [AW-1:0] tx_wp_next, tx_rp_next, rx_wp_next, rx_rp_next;
    logic [AW:0] tx_cnt_reg, tx_cnt_next, rx_cnt_reg, rx_cnt_next;
    stw_pkg::stw_state_t state_reg, state_next;
    logic [31:0] shift_reg, shift_next;
    logic [5:0] bits_reg, bits_next;
    logic [7:0] div_reg, div_next;
    logic sclk_reg, sclk_next, sel_n_reg, sel_n_next;
    logic sd_out_reg, sd_out_next, sd_oe_n_reg, sd_oe_n_next;
    logic sin_meta_reg, sin_sync_reg;

    logic hit, wr, rd, tx_push, tx_pop, rx_push, rx_pop;
    logic en, three_wire, tick, set_ovr, set_done;
    logic [7:0] ofs, half;
    logic [4:0] command_length, data_size;
    localparam int IRQ_W_L = stw_pkg::IRQ_W - 1;
    logic [IRQ_W_L:0] raw_view;
    logic [31:0] stat_view;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    // (RQ10) Base address compare
    assign hit = bus.addr[31:8] == stw_pkg::BASE_ADDR[31:8];
    assign ofs = bus.addr[7:0];
    assign wr = bus.wr & hit;
    assign rd = bus.rd & hit;
    assign en = ctrl0_reg[stw_pkg::EN_BIT];
    // (RQ2) Three-wire selection
    assign three_wire = ctrl0_reg[stw_pkg::FMT_LSB +: 2] == stw_pkg::FMT_THREE_WIRE;
    assign command_length = ctrl1_reg[stw_pkg::CSS_LSB +: 5];
    assign data_size = ctrl0_reg[stw_pkg::DSS_LSB +: 5];
    assign tx_push = wr && ofs == stw_pkg::OFS_DATA && tx_cnt_reg != FULL;
    assign rx_pop = rd && ofs == stw_pkg::OFS_DATA && rx_cnt_reg != '0;
    // Odd divisors round down; zero and one still give a bit clock
    assign half = (presc_reg[7:1] == 7'h00) ? 8'h01 : {1'b0, presc_reg[7:1]};
    assign tick = div_reg == 8'h00;

    // (RQ15) Unmasked sources
    assign raw_view = {sticky_reg[1], tx_cnt_reg == '0, sticky_reg[0]};
    // (RQ12) Status view; empty FIFOs with the engine idle give the reset value
    assign stat_view = {27'h0, state_reg != stw_pkg::ST_IDLE, rx_cnt_reg == FULL,
        rx_cnt_reg != '0, tx_cnt_reg != FULL, tx_cnt_reg == '0};

    // ----------------------------------------
    // Serial engine
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        bits_next = bits_reg;
        div_next = tick ? half - 8'h01 : div_reg - 8'h01;
        sclk_next = sclk_reg;
        sel_n_next = sel_n_reg;
        sd_out_next = sd_out_reg;
        sd_oe_n_next = sd_oe_n_reg;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        set_ovr = 1'b0;
        set_done = 1'b0;
        unique case (state_reg)
            stw_pkg::ST_IDLE: begin
                div_next = half - 8'h01;
                sclk_next = 1'b0;
                sel_n_next = 1'b1;
                // (RQ3) Line released unless sending
                sd_oe_n_next = 1'b1;
                // (RQ1) Four-wire format starts no frame here
                if (en && three_wire && tx_cnt_reg != '0) begin
                    // (RQ4) Command length sets sent bits
                    shift_next = tx_mem[tx_rp_reg] << (5'h1F - command_length);
                    bits_next = {1'b0, command_length} + 6'h01;
                    sd_out_next = shift_next[31];
                    sd_oe_n_next = 1'b0;
                    sel_n_next = 1'b0;
                    tx_pop = 1'b1;
                    state_next = stw_pkg::ST_SEND;
                end else if (en && three_wire && receive_frame_count_reg != '0) begin
                    // (RQ5) Data size sets received bits
                    shift_next = '0;
                    bits_next = {1'b0, data_size} + 6'h01;
                    sel_n_next = 1'b0;
                    state_next = stw_pkg::ST_RECV;
                end
            end
            stw_pkg::ST_SEND, stw_pkg::ST_RECV: begin
                if (tick) begin
                    sclk_next = ~sclk_reg;
                    if (!sclk_reg && state_reg == stw_pkg::ST_RECV) begin
                        shift_next = {shift_reg[30:0], sin_sync_reg};
                    end
                    if (sclk_reg) begin
                        bits_next = bits_reg - 6'h01;
                        shift_next = (state_reg == stw_pkg::ST_SEND) ?
                            shift_reg << 1 : shift_reg;
                        sd_out_next = shift_reg[30];
                        // (RQ9) Busy drops with the last falling edge
                        if (bits_reg == 6'h01) begin
                            state_next = stw_pkg::ST_IDLE;
                            sel_n_next = 1'b1;
                            sd_oe_n_next = 1'b1;
                            set_done = 1'b1;
                            if (state_reg == stw_pkg::ST_RECV) begin
                                rx_push = rx_cnt_reg != FULL;
                                set_ovr = rx_cnt_reg == FULL;
                            end
                        end
                    end
                end
            end
            default: state_next = stw_pkg::ST_IDLE;
        endcase
    end

    // ----------------------------------------
    // FIFO pointers
    // ----------------------------------------
    always_comb begin
        tx_wp_next = tx_push ? ptr_inc(tx_wp_reg) : tx_wp_reg;
        tx_rp_next = tx_pop ? ptr_inc(tx_rp_reg) : tx_rp_reg;
        rx_wp_next = rx_push ? ptr_inc(rx_wp_reg) : rx_wp_reg;
        rx_rp_next = rx_pop ? ptr_inc(rx_rp_reg) : rx_rp_reg;
        tx_cnt_next = tx_cnt_reg + (AW + 1)'(tx_push) - (AW + 1)'(tx_pop);
        rx_cnt_next = rx_cnt_reg + (AW + 1)'(rx_push) - (AW + 1)'(rx_pop);
    end

    // ----------------------------------------
    // Register writes and read mux
    // ----------------------------------------
    always_comb begin
        ctrl0_next = ctrl0_reg;
        ctrl1_next = ctrl1_reg;
        presc_next = presc_reg;
        imask_next = imask_reg;
        dma_next = dma_reg;
        receive_frame_count_next = receive_frame_count_reg;
        dummy_next = dummy_reg;
        txfrm_next = txfrm_reg;
        itest_next = itest_reg;
        tdata_next = tdata_reg;
        // (RQ20) One count per received frame
        if (state_reg == stw_pkg::ST_IDLE && state_next == stw_pkg::ST_RECV) begin
            receive_frame_count_next = receive_frame_count_reg - 32'h0000_0001;
        end
        // (RQ19) Sent frames count down
        if (tx_pop && txfrm_reg != '0) begin
            txfrm_next = txfrm_reg - 32'h0000_0001;
        end
        // (RQ17) Set wins over the clear
        sticky_next = sticky_reg | {set_done, set_ovr};
        if (wr) begin
            // (RQ22) Read-only and unmapped writes fall through
            unique case (ofs)
                stw_pkg::OFS_CTRL0: ctrl0_next = bus.wdata;
                stw_pkg::OFS_CTRL1: ctrl1_next = bus.wdata;
                // (RQ13) Prescale store
                stw_pkg::OFS_PRESC: presc_next = bus.wdata;
                // (RQ14) Mask store
                stw_pkg::OFS_IMASK: imask_next = bus.wdata;
                stw_pkg::OFS_DMA: dma_next = bus.wdata;
                // (RQ18) Software load wins over the countdown
                stw_pkg::OFS_RECEIVE_FRAME_COUNT: receive_frame_count_next = bus.wdata;
                stw_pkg::OFS_DUMMY: dummy_next = bus.wdata;
                stw_pkg::OFS_TXFRM: txfrm_next = bus.wdata;
                stw_pkg::OFS_ITEST: itest_next = bus.wdata;
                stw_pkg::OFS_TDATA: tdata_next = bus.wdata;
                stw_pkg::OFS_ICLR: sticky_next = (sticky_reg &
                    ~{bus.wdata[stw_pkg::IRQ_DONE], bus.wdata[stw_pkg::IRQ_OVR]})
                    | {set_done, set_ovr};
                default: ;
            endcase
        end
        rdata_next = '0;
        if (rd) begin
            unique case (ofs)
                // (RQ11) Control word readback
                stw_pkg::OFS_CTRL0: rdata_next = ctrl0_reg;
                stw_pkg::OFS_CTRL1: rdata_next = ctrl1_reg;
                stw_pkg::OFS_DATA: rdata_next = rx_cnt_reg != '0 ? rx_mem[rx_rp_reg] : '0;
                stw_pkg::OFS_STAT: rdata_next = stat_view;
                stw_pkg::OFS_PRESC: rdata_next = presc_reg;
                stw_pkg::OFS_IMASK: rdata_next = imask_reg;
                stw_pkg::OFS_RAW: rdata_next = {29'h0, raw_view};
                // (RQ16) Masked view
                stw_pkg::OFS_MASKED: rdata_next = {29'h0, raw_view & imask_reg[2:0]};
                stw_pkg::OFS_DMA: rdata_next = dma_reg;
                stw_pkg::OFS_RECEIVE_FRAME_COUNT: rdata_next = receive_frame_count_reg;
                stw_pkg::OFS_DUMMY: rdata_next = dummy_reg;
                stw_pkg::OFS_TXFRM: rdata_next = txfrm_reg;
                stw_pkg::OFS_ITEST: rdata_next = itest_reg;
                stw_pkg::OFS_TDATA: rdata_next = tdata_reg;
                default: rdata_next = '0;
            endcase
        end
        // (RQ21) Mask bit one routes the source
        irq_next = |(raw_view & imask_reg[2:0]);
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        // Data line only after two flops
        sin_meta_reg <= sd_in;
        sin_sync_reg <= sin_meta_reg;
        if (tx_push) begin
            tx_mem[tx_wp_reg] <= bus.wdata;
        end
        if (rx_push) begin
            rx_mem[rx_wp_reg] <= shift_next;
        end
        if (sys_rst) begin
            ctrl0_reg <= stw_pkg::RST_CTRL0;
            ctrl1_reg <= stw_pkg::RST_ZERO;
            presc_reg <= stw_pkg::RST_ZERO;
            imask_reg <= stw_pkg::RST_ZERO;
            dma_reg <= stw_pkg::RST_ZERO;
            receive_frame_count_reg <= stw_pkg::RST_ZERO;
            dummy_reg <= stw_pkg::RST_ZERO;
            txfrm_reg <= stw_pkg::RST_ZERO;
            itest_reg <= stw_pkg::RST_ZERO;
            tdata_reg <= stw_pkg::RST_ZERO;
            rdata_reg <= stw_pkg::RST_ZERO;
            sticky_reg <= '0;
            irq_reg <= 1'b0;
            tx_wp_reg <= '0;
            tx_rp_reg <= '0;
            rx_wp_reg <= '0;
            rx_rp_reg <= '0;
            tx_cnt_reg <= '0;
            rx_cnt_reg <= '0;
            state_reg <= stw_pkg::ST_IDLE;
            shift_reg <= '0;
            bits_reg <= '0;
            div_reg <= '0;
            sclk_reg <= 1'b0;
            sel_n_reg <= 1'b1;
            sd_out_reg <= 1'b0;
            sd_oe_n_reg <= 1'b1;
        end else begin
            ctrl0_reg <= ctrl0_next;
            ctrl1_reg <= ctrl1_next;
            presc_reg <= presc_next;
            imask_reg <= imask_next;
            dma_reg <= dma_next;
            receive_frame_count_reg <= receive_frame_count_next;
            dummy_reg <= dummy_next;
            txfrm_reg <= txfrm_next;
            itest_reg <= itest_next;
            tdata_reg <= tdata_next;
            rdata_reg <= rdata_next;
            sticky_reg <= sticky_next;
            irq_reg <= irq_next;
            tx_wp_reg <= tx_wp_next;
            tx_rp_reg <= tx_rp_next;
            rx_wp_reg <= rx_wp_next;
            rx_rp_reg <= rx_rp_next;
            tx_cnt_reg <= tx_cnt_next;
            rx_cnt_reg <= rx_cnt_next;
            state_reg <= state_next;
            shift_reg <= shift_next;
            bits_reg <= bits_next;
            div_reg <= div_next;
            sclk_reg <= sclk_next;
            sel_n_reg <= sel_n_next;
            sd_out_reg <= sd_out_next;
            sd_oe_n_reg <= sd_oe_n_next;
        end
    end

    assign rd_data = rdata_reg;
    assign sclk = sclk_reg;
    assign sel_n = sel_n_reg;
    assign sd_out = sd_out_reg;
    assign sd_oe_n = sd_oe_n_reg;
    assign irq = irq_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    ctrl_reset_a: // (RQ11)
        assert property ($past(sys_rst) |-> ctrl0_reg == stw_pkg::RST_CTRL0)
        else $error("control word reset value wrong");
    stat_reset_a: // (RQ12)
        assert property ($past(sys_rst) |-> stat_view == stw_pkg::RST_STAT)
        else $error("status reset value wrong");
    fourwire_quiet_a: // (RQ1)
        assert property (state_reg == stw_pkg::ST_IDLE && !three_wire
            |=> state_reg == stw_pkg::ST_IDLE)
        else $error("frame started outside three-wire format");
    send_len_a: // (RQ4)
        assert property (state_reg == stw_pkg::ST_IDLE && state_next == stw_pkg::ST_SEND
            |=> bits_reg == {1'b0, $past(command_length)} + 6'h01 && !sd_oe_n_reg)
        else $error("send length or drive wrong");
    recv_len_a: // (RQ5)
        assert property (state_reg == stw_pkg::ST_IDLE && state_next == stw_pkg::ST_RECV
            |=> bits_reg == {1'b0, $past(data_size)} + 6'h01 && sd_oe_n_reg)
        else $error("receive length or release wrong");
    line_dir_a: // (RQ3)
        assert property (state_reg == stw_pkg::ST_RECV |-> sd_oe_n_reg && !sel_n_reg)
        else $error("line driven during receive");
    busy_read_a: // (RQ9)
        assert property (rd && ofs == stw_pkg::OFS_STAT
            |=> rd_data[stw_pkg::ST_BUSY] == $past(state_reg != stw_pkg::ST_IDLE))
        else $error("busy flag mismatch");
    unmapped_a: // (RQ22)
        assert property (bus.rd && !hit |=> rd_data == '0)
        else $error("outside read not zero");
    presc_store_a: // (RQ13)
        assert property (wr && ofs == stw_pkg::OFS_PRESC |=> presc_reg == $past(bus.wdata))
        else $error("prescale not stored");
    irq_route_a: // (RQ21)
        assert property (##1 irq_reg == $past(|(raw_view & imask_reg[2:0])))
        else $error("interrupt routing wrong");
    receive_frame_count_count_a: // (RQ20)
        assert property (state_reg == stw_pkg::ST_IDLE && state_next == stw_pkg::ST_RECV
            && !(wr && ofs == stw_pkg::OFS_RECEIVE_FRAME_COUNT) |=> receive_frame_count_reg == $past(receive_frame_count_reg) - 32'h1)
        else $error("receive count not decremented");
    clear_ovr_a: // (RQ17)
        assert property (wr && ofs == stw_pkg::OFS_ICLR && bus.wdata[0] && !set_ovr
            |=> !sticky_reg[0])
        else $error("overrun not cleared");

    send_cov: cover property (state_reg == stw_pkg::ST_SEND ##1 state_reg == stw_pkg::ST_IDLE);
    recv_cov: cover property (rx_push);
    ovr_cov: cover property (set_ovr);
    irq_cov: cover property (irq_reg);
endmodule : stw_ctrl
